// *** design/acr_pkg.sv ***
package acr_pkg;
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  IDX_PIN_CFG     = 4'h4;
    localparam logic [3:0]  IDX_MISC        = 4'h5;
    localparam logic [3:0]  IDX_REF         = 4'h6;
    localparam logic [3:0]  IDX_OFS_LO      = 4'h7;
    localparam logic [3:0]  IDX_OFS_MID     = 4'h8;
    localparam logic [3:0]  IDX_OFS_HI      = 4'h9;
    localparam logic [3:0]  IDX_GAIN_LO     = 4'hA;
    localparam logic [3:0]  IDX_GAIN_MID    = 4'hB;
    localparam logic [3:0]  IDX_GAIN_HI     = 4'hC;
    localparam logic [7:0]  RST_PIN_CFG     = 8'h00;
    localparam logic [7:0]  RST_MISC        = 8'h00;
    localparam logic [7:0]  RST_REF         = 8'h05;
    localparam logic [7:0]  RST_OFS_BYTE    = 8'h00;
    localparam logic [7:0]  RST_GAIN_LO     = 8'h00;
    localparam logic [7:0]  RST_GAIN_MID    = 8'h00;
    localparam logic [7:0]  RST_GAIN_HI     = 8'h40;
    localparam int          BIT_SOFT_POWER_DOWN        = 7;
    localparam int          BIT_STATUS      = 6;
    localparam int          BIT_CRC         = 5;
    localparam int          BIT_AUTORST     = 4;
    localparam logic [7:0]  REF_MASK        = 8'h0F;
    localparam int          CAL_W           = 24;
    localparam int          GAIN_SHIFT      = 22;
    localparam int          NUM_PINS        = 4;
endpackage : acr_pkg

// *** design/acr_cal_path.sv ***
module acr_cal_path (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         ce_i,
    input  wire logic                         valid_i,
    input  wire logic [acr_pkg::CAL_W-1:0]    raw_i,
    input  wire logic [acr_pkg::CAL_W-1:0]    offset_cal_word_i,
    input  wire logic [acr_pkg::CAL_W-1:0]    gain_cal_word_i,
    output logic                              valid_o,
    output logic [acr_pkg::CAL_W-1:0]         data_o
);
    import acr_pkg::*;

    // ****************************************
    // Offset then gain correction
    // ****************************************
    logic signed [CAL_W:0]     diff;
    logic signed [2*CAL_W+1:0] prod;
    logic signed [2*CAL_W+1:0] scaled;
    logic        [CAL_W-1:0]   sat;
    localparam logic signed [2*CAL_W+1:0] MAXV = (2*CAL_W+2)'(2**(CAL_W-1) - 1);
    localparam logic signed [2*CAL_W+1:0] MINV = -(2*CAL_W+2)'(2**(CAL_W-1));

    assign diff   = $signed({raw_i[CAL_W-1], raw_i})
                  - $signed({offset_cal_word_i[CAL_W-1], offset_cal_word_i});
    // Gain word is unsigned, so zero-extend before the signed product
    assign prod   = (2*CAL_W+2)'(diff * $signed({1'b0, gain_cal_word_i}));
    assign scaled = prod >>> GAIN_SHIFT;
    // Saturate rather than wrap on gain above unity
    assign sat    = (scaled > MAXV) ? MAXV[CAL_W-1:0] :
                    (scaled < MINV) ? MINV[CAL_W-1:0] : scaled[CAL_W-1:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            data_o  <= '0;
        end else if (ce_i) begin
            valid_o <= valid_i;
            if (valid_i) begin
                data_o <= sat;
            end
        end
    end

    property p_cal_order;
        @(posedge clk_i) disable iff (rst_i)
            ce_i && valid_i && gain_cal_word_i == 24'h400000
            && diff < 25'sh7FFFFF && diff > -25'sh800000
            |=> data_o == $past(raw_i - offset_cal_word_i);
    endproperty
    a_cal_order: assert property (p_cal_order)
        else $error("unity gain result is not raw minus offset");
endmodule : acr_cal_path

// *** design/acr_regs.sv ***
// The implementer's own choice: the Wishbone slave port.
module acr_regs (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    input  wire logic                       cyc_i,
    input  wire logic                       stb_i,
    input  wire logic                       we_i,
    input  wire logic [31:0]                adr_i,
    input  wire logic [3:0]                 sel_i,
    input  wire logic [31:0]                dat_i,
    output logic [31:0]                     dat_o,
    output logic                            ack_o,
    output logic                            err_o,
    input  wire logic [acr_pkg::NUM_PINS-1:0] pin_level_i,
    output logic [acr_pkg::NUM_PINS-1:0]    pin_level_o,
    output logic [acr_pkg::NUM_PINS-1:0]    pin_level_oe_n_o,
    output logic [acr_pkg::NUM_PINS-1:0]    pin_to_input_connect_o,
    output logic                            soft_power_down_o,
    output logic                            status_byte_enable_o,
    output logic                            crc_check_enable_o,
    output logic                            serial_auto_reset_enable_o,
    output logic [1:0]                      ref_positive_select_o,
    output logic [1:0]                      ref_negative_select_o,
    input  wire logic                       conv_valid_i,
    input  wire logic [acr_pkg::CAL_W-1:0]  conv_raw_i,
    output logic                            conv_valid_o,
    output logic [acr_pkg::CAL_W-1:0]       conv_data_o
);
    import acr_pkg::*;

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0]        pin_cfg_reg;
    logic [7:0]        misc_reg;
    logic [7:0]        ref_reg;
    logic [7:0]        cal_reg [6];
    logic              ack_reg;
    logic              err_reg;
    logic [31:0]       rdata_reg;

    // ****************************************
    // Bus decode
    // ****************************************
    wire               req      = cyc_i && stb_i && !ack_reg && !err_reg;
    wire [ADDR_W-1:0]  idx      = adr_i[ADDR_W+1:2];
    // Index form: byte address is four times the register index
    wire               in_range = (adr_i[31:ADDR_W+2] == '0) && (adr_i[1:0] == 2'b00);
    wire               hit_cfg  = in_range && idx == IDX_PIN_CFG;
    wire               hit_misc = in_range && idx == IDX_MISC;
    wire               hit_ref  = in_range && idx == IDX_REF;
    wire               hit_cal  = in_range && idx >= IDX_OFS_LO && idx <= IDX_GAIN_HI;
    wire               mapped   = hit_cfg || hit_misc || hit_ref || hit_cal;
    wire               wr       = req && mapped && we_i && sel_i[0];
    wire [2:0]         cal_sel  = 3'(idx - IDX_OFS_LO);
    wire [NUM_PINS-1:0] dir_in  = pin_cfg_reg[NUM_PINS-1:0];
    // Input pins report the pad, output pins report the driven value
    wire [NUM_PINS-1:0] pin_rd  = (dir_in & pin_level_i) | (~dir_in & misc_reg[NUM_PINS-1:0]);
    wire [7:0]         rd_byte  = hit_cfg  ? pin_cfg_reg :
                                  hit_misc ? {misc_reg[7:NUM_PINS], pin_rd} :
                                  hit_ref  ? ref_reg :
                                  hit_cal  ? cal_reg[cal_sel] : 8'h00;
    wire [CAL_W-1:0]   ofs_word = {cal_reg[2], cal_reg[1], cal_reg[0]};
    wire [CAL_W-1:0]   gain_word = {cal_reg[5], cal_reg[4], cal_reg[3]};

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_cfg_reg <= RST_PIN_CFG;
            misc_reg    <= RST_MISC;
            ref_reg     <= RST_REF;
        end else if (ce_i && wr) begin
            if (hit_cfg) begin
                pin_cfg_reg <= dat_i[7:0];
            end
            if (hit_misc) begin
                misc_reg <= dat_i[7:0];
            end
            if (hit_ref) begin
                // Reserved upper bits kept zero; reserved codes stored as written
                ref_reg <= dat_i[7:0] & REF_MASK;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_cal
            localparam logic [7:0] RV = (g == 5) ? RST_GAIN_HI :
                                        (g == 4) ? RST_GAIN_MID :
                                        (g == 3) ? RST_GAIN_LO : RST_OFS_BYTE;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cal_reg[g] <= RV;
                end else if (ce_i && wr && hit_cal && cal_sel == 3'(g)) begin
                    // Each byte lands on its own; partial words apply at once
                    cal_reg[g] <= dat_i[7:0];
                end
            end
        end
    endgenerate

    // ****************************************
    // Bus answer
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= '0;
        end else if (ce_i) begin
            ack_reg   <= req && mapped;
            err_reg   <= req && !mapped;
            rdata_reg <= (req && mapped && !we_i) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    assign ack_o = ack_reg;
    assign err_o = err_reg;
    assign dat_o = rdata_reg;

    // ****************************************
    // Pin and control outputs
    // ****************************************
    assign pin_to_input_connect_o     = pin_cfg_reg[7:NUM_PINS];
    assign pin_level_oe_n_o           = dir_in;
    assign pin_level_o                = misc_reg[NUM_PINS-1:0];
    assign soft_power_down_o          = misc_reg[BIT_SOFT_POWER_DOWN];
    assign status_byte_enable_o       = misc_reg[BIT_STATUS];
    assign crc_check_enable_o         = misc_reg[BIT_CRC];
    assign serial_auto_reset_enable_o = misc_reg[BIT_AUTORST];
    assign ref_positive_select_o      = ref_reg[3:2];
    assign ref_negative_select_o      = ref_reg[1:0];

    acr_cal_path u_cal (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .ce_i              (ce_i),
        .valid_i           (conv_valid_i),
        .raw_i             (conv_raw_i),
        .offset_cal_word_i (ofs_word),
        .gain_cal_word_i   (gain_word),
        .valid_o           (conv_valid_o),
        .data_o            (conv_data_o)
    );

    // ****************************************
    // Checks
    // ****************************************
    property p_reset_vals;
        @(posedge clk_i) rst_i |=> misc_reg == 8'h00 && ref_reg == 8'h05
            && pin_cfg_reg == 8'h00 && gain_word == 24'h400000 && ofs_word == 24'h000000;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    property p_ref_upper_zero;
        @(posedge clk_i) disable iff (rst_i) ref_reg[7:4] == 4'h0;
    endproperty
    a_ref_upper_zero: assert property (p_ref_upper_zero)
        else $error("reference reserved bits set");

    property p_misc_write;
        @(posedge clk_i) disable iff (rst_i) ce_i && wr && hit_misc
            |=> soft_power_down_o == $past(dat_i[7]) && status_byte_enable_o == $past(dat_i[6])
            && crc_check_enable_o == $past(dat_i[5])
            && serial_auto_reset_enable_o == $past(dat_i[4]);
    endproperty
    a_misc_write: assert property (p_misc_write)
        else $error("control bits not taken");

    property p_pin_out;
        @(posedge clk_i) disable iff (rst_i) ce_i && wr && hit_misc
            |=> pin_level_o == $past(dat_i[3:0]);
    endproperty
    a_pin_out: assert property (p_pin_out)
        else $error("pin drive level not taken");

    // Frozen enable must hold the pin config, misc and reference registers and the ack
    property p_ce_freeze;
        @(posedge clk_i) disable iff (rst_i) !ce_i
            |=> $stable(misc_reg) && $stable(ref_reg) && $stable(pin_cfg_reg) && $stable(ack_o);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state moved while clock enable low");

    property p_pin_dir;
        @(posedge clk_i) disable iff (rst_i) ce_i && wr && hit_cfg
            |=> pin_level_oe_n_o == $past(dat_i[3:0]) && pin_to_input_connect_o == $past(dat_i[7:4]);
    endproperty
    a_pin_dir: assert property (p_pin_dir)
        else $error("pin config not applied");

    property p_pin_read;
        @(posedge clk_i) disable iff (rst_i) ce_i && req && hit_misc && !we_i
            |=> ack_o && dat_o[3:0] == (($past(pin_level_i) & $past(dir_in))
            | ($past(pin_level_o) & ~$past(dir_in)));
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("pin level read wrong");

    property p_ref_fields;
        @(posedge clk_i) disable iff (rst_i) ce_i && wr && hit_ref
            |=> ref_positive_select_o == $past(dat_i[3:2])
            && ref_negative_select_o == $past(dat_i[1:0]);
    endproperty
    a_ref_fields: assert property (p_ref_fields)
        else $error("reference fields wrong");

    property p_cal_write;
        @(posedge clk_i) disable iff (rst_i) ce_i && wr && idx == IDX_GAIN_HI && in_range
            |=> gain_word[23:16] == $past(dat_i[7:0]);
    endproperty
    a_cal_write: assert property (p_cal_write)
        else $error("gain high byte not written");

    property p_ofs_low;
        @(posedge clk_i) disable iff (rst_i) ce_i && wr && idx == IDX_OFS_LO && in_range
            |=> ofs_word[7:0] == $past(dat_i[7:0]);
    endproperty
    a_ofs_low: assert property (p_ofs_low)
        else $error("offset low byte misplaced");

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) ack_o && ce_i |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held two cycles");
endmodule : acr_regs

// *** dv/acr_host_model.sv ***
// ****************************************
// Host side bus master
// ****************************************
module acr_host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i,
    input  wire logic        err_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [31:0]      adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 32'h00000000;
        sel_o = 4'h0;
        dat_o = 32'h00000000;
    end
    // Waits for ack or err with no bound; the bench timeout cuts a hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic e);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {24'h000000, a};
        sel_o <= 4'h1;
        dat_o <= {24'h000000, d};
        do @(posedge clk_i); while (ack_i !== 1'b1 && err_i !== 1'b1);
        q = dat_i[7:0];
        e = err_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
    endtask : xfer
    // Upper nibble always zero, reserved codes never chosen
    task automatic ref_wr(input logic [1:0] p, input logic [1:0] n);
        logic [7:0] q;
        logic       e;
        xfer(1'b1, 8'h18, {4'h0, p, n}, q, e);
    endtask : ref_wr
    // Whole word before use, low byte first
    task automatic cal_wr(input logic [7:0] base, input logic [23:0] w);
        logic [7:0] q;
        logic       e;
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, base + 8'(i * 4), w[i*8 +: 8], q, e);
        end
    endtask : cal_wr
endmodule : acr_host_model

// *** dv/adc_config_calib_regs_tb_top.sv ***
// ****************************************
// Register slice bench
// ****************************************
module adc_config_calib_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import acr_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce = 1'b1;
    logic        cyc, stb, we, ack, err, pd, sb, crc, ar, cv_i, cv_o, e;
    logic [31:0] adr, wdat, rdat;
    logic [3:0]  sel, pad_drv, pin_o, oe_n, conn, pin_i;
    logic [1:0]  rp, rn;
    logic [23:0] raw, cdat;
    logic [7:0]  q;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cyc_cnt = 0;
    logic [7:0]  rst_tab [9] = '{RST_PIN_CFG, RST_MISC, RST_REF, RST_OFS_BYTE,
        RST_OFS_BYTE, RST_OFS_BYTE, RST_GAIN_LO, RST_GAIN_MID, RST_GAIN_HI};
    // Pad level: driven pins show their own drive, inputs the outside level
    assign pin_i = (oe_n & pad_drv) | (~oe_n & pin_o);
    acr_regs uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .err_o(err), .pin_level_i(pin_i),
        .pin_level_o(pin_o), .pin_level_oe_n_o(oe_n), .pin_to_input_connect_o(conn),
        .soft_power_down_o(pd), .status_byte_enable_o(sb), .crc_check_enable_o(crc),
        .serial_auto_reset_enable_o(ar), .ref_positive_select_o(rp),
        .ref_negative_select_o(rn), .conv_valid_i(cv_i), .conv_raw_i(raw),
        .conv_valid_o(cv_o), .conv_data_o(cdat));
    acr_host_model host (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .err_i(err),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    task automatic conv(input logic [23:0] r, input logic [23:0] x);
        @(posedge clk_i);
        cv_i <= 1'b1;
        raw  <= r;
        @(posedge clk_i);
        cv_i <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, cv_o}, 32'h1);
        chk({8'h00, cdat}, {8'h00, x});
    endtask : conv
    // Whole run is well under this; reaching it means a hang
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        // Pad level 4'h5 (pins 0 and 2 high, 1 and 3 low) so pad reads differ from stored drive bits
        pad_drv = 4'h5;
        cv_i = 1'b0;
        raw = 24'h000000;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            host.xfer(1'b0, 8'h10 + 8'(i * 4), 8'h00, q, e);
            chk({24'h0, q}, {24'h0, rst_tab[i]});
        end
        chk({24'h0, pd, sb, crc, ar, rp, rn}, 32'h5);
        conv(24'h123456, 24'h123456);
        host.xfer(1'b1, 8'h10, 8'hA5, q, e);
        chk({24'h0, conn, oe_n}, 32'hA5);
        host.xfer(1'b1, 8'h14, 8'hF3, q, e);
        chk({24'h0, pd, sb, crc, ar, pin_o}, 32'hF3);
        host.xfer(1'b0, 8'h14, 8'h00, q, e);
        chk({24'h0, q}, 32'hF7);
        host.xfer(1'b1, 8'h14, 8'h5C, q, e);
        chk({24'h0, pd, sb, crc, ar, pin_o}, 32'h5C);
        host.xfer(1'b0, 8'h14, 8'h00, q, e);
        chk({24'h0, q}, 32'h5D);
        // Clock enable low holds off the bus and all state
        ce <= 1'b0;
        fork
            host.xfer(1'b1, 8'h14, 8'h80, q, e);
            begin
                repeat (3) @(posedge clk_i);
                chk({30'h0, ack, pd}, 32'h0);
                ce <= 1'b1;
            end
        join
        chk({24'h0, pd, sb, crc, ar, pin_o}, 32'h80);
        for (int p = 1; p < 4; p++) begin
            for (int n = 1; n < 4; n++) begin
                host.ref_wr(2'(p), 2'(n));
                host.xfer(1'b0, 8'h18, 8'h00, q, e);
                chk({24'h0, q}, 32'(p * 4 + n));
                chk({28'h0, rp, rn}, 32'(p * 4 + n));
            end
        end
        host.cal_wr(8'h1C, 24'h000010);
        host.cal_wr(8'h28, 24'h200000);
        conv(24'h000110, 24'h000080);
        host.xfer(1'b0, 8'h1C, 8'h00, q, e);
        chk({24'h0, q}, 32'h10);
        host.xfer(1'b0, 8'h30, 8'h00, q, e);
        chk({24'h0, q}, 32'h20);
        host.cal_wr(8'h1C, 24'hFFFFF0);
        host.cal_wr(8'h28, 24'h800000);
        conv(24'h7FFFFF, 24'h7FFFFF);
        host.xfer(1'b0, 8'h34, 8'h00, q, e);
        chk({31'h0, e}, 32'h1);
        host.xfer(1'b1, 8'h15, 8'hFF, q, e);
        chk({31'h0, e}, 32'h1);
        host.xfer(1'b0, 8'h14, 8'h00, q, e);
        chk({24'h0, q}, 32'h85);
        results();
    end
endmodule : adc_config_calib_regs_tb_top
